// >>> include/cocr_pkg.sv
package cocr_pkg;

  // Register offsets on the 8-bit host port
  localparam logic [7:0] COCR_OFS_HOLD    = 8'h08;
  localparam logic [7:0] COCR_OFS_OUTDIS  = 8'h0a;
  localparam logic [7:0] COCR_OFS_INPD    = 8'h0b;
  localparam logic [7:0] COCR_OFS_COARSE  = 8'h10;
  localparam logic [7:0] COCR_OFS_FINE_HI = 8'h11;
  localparam logic [7:0] COCR_OFS_FINE_LO = 8'h12;
  localparam logic [7:0] COCR_OFS_PHASE   = 8'h13;
  localparam logic [7:0] COCR_OFS_STATUS  = 8'h14;

  // Field positions
  localparam int COCR_HOLD_LSB   = 4;
  localparam int COCR_HOLD_MSB   = 5;
  localparam int COCR_OUTDIS_BIT = 2;
  localparam int COCR_INPD_BIT   = 0;
  localparam int COCR_COMMIT_BIT = 7;
  localparam int COCR_FINE_HI_W  = 7;
  localparam int COCR_FINE_W     = 15;
  localparam int COCR_ST_SETTLED = 0;
  localparam int COCR_ST_LEVEL   = 1;
  localparam int COCR_ST_STEPSEL = 2;

  // Reset values
  localparam logic [7:0] COCR_RST_HOLD    = 8'h00;
  localparam logic [7:0] COCR_RST_OUTDIS  = 8'h00;
  localparam logic [7:0] COCR_RST_INPD    = 8'h40;
  localparam logic [7:0] COCR_RST_COARSE  = 8'h00;
  localparam logic [7:0] COCR_RST_FINE_HI = 8'h80;
  localparam logic [7:0] COCR_RST_FINE_LO = 8'h00;
  // Reserved bit 6 of the input powerdown register reads back as one
  localparam logic [7:0] COCR_INPD_RSVD   = 8'h40;

  // Output hold-level codes
  typedef enum logic [1:0] {
    COCR_HOLD_NORMAL = 2'h0,
    COCR_HOLD_LOW    = 2'h1,
    COCR_HOLD_HIGH   = 2'h2,
    COCR_HOLD_RSVD   = 2'h3
  } cocr_hold_t;

  // Timing
  localparam longint COCR_CLK_HZ      = 50_000_000;
  localparam longint COCR_SLEW_TIME_S = 20;
  localparam longint COCR_PHASE_STEPS = 256;
  // Longest time, so rounded down
  localparam longint COCR_SLEW_STEP_CYC =
    (COCR_SLEW_TIME_S * COCR_CLK_HZ) / COCR_PHASE_STEPS;
  localparam int COCR_DIV_HALF_DEF = 4;

endpackage

// >>> src/cocr_sync2.sv
`timescale 1ns/1ps
module cocr_sync2
  import cocr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } cocr_sync_st_t;

  cocr_sync_st_t st_reg;
  cocr_sync_st_t st_next;

  // Only the second stage is visible to logic
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = async_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;

endmodule

// >>> src/cocr_phase_slew.sv
`timescale 1ns/1ps
module cocr_phase_slew
  import cocr_pkg::*;
#(
  parameter int STEP_CYC = 16
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              enable,
  input  wire logic signed [7:0] target,
  output logic signed [7:0]      applied,
  output logic                   step_up,
  output logic                   step_dn,
  output logic                   settled
);

  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least one");
  end

  typedef struct packed {
    logic [31:0]       timer;
    logic signed [7:0] applied;
    logic              up;
    logic              dn;
  } cocr_slew_st_t;

  cocr_slew_st_t st_reg;
  cocr_slew_st_t st_next;

  // One clock of phase per step keeps the output free of sudden jumps
  always_comb begin
    st_next    = st_reg;
    st_next.up = 1'b0;
    st_next.dn = 1'b0;
    if (st_reg.timer != 32'h0) begin
      st_next.timer = st_reg.timer - 32'h1;
    end else if (enable && st_reg.applied != target) begin
      st_next.timer = 32'(STEP_CYC - 1);
      if (st_reg.applied < target) begin
        st_next.applied = st_reg.applied + 8'sh1;
        st_next.up      = 1'b1;
      end else begin
        st_next.applied = st_reg.applied - 8'sh1;
        st_next.dn      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign applied = st_reg.applied;
  assign step_up = st_reg.up;
  assign step_dn = st_reg.dn;
  assign settled = (st_reg.applied == target);

endmodule

// >>> src/cocr_top.sv
// Operation
// - Hold code 01 holds output low
// - Hold code 10 holds output high
// - Hold entry and exit on edges only
// - Disable bit powers down output buffer
// - Disable also powers down output divider
// - Powerdown bit disables input clock buffer
// - Step select low applies coarse delay
// - Coarse delay is signed, -128 to 127
// - Coarse delay moves gradually over 20 s
// - Commit low keeps the held old value
// - Commit high uses register value directly
// - Fine value is upper 7 plus lower 8
`timescale 1ns/1ps
module cocr_top
  import cocr_pkg::*;
#(
  parameter int DIV_HALF       = COCR_DIV_HALF_DEF,
  parameter int SLEW_STEP_CYC  = int'(COCR_SLEW_STEP_CYC)
)(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  input  wire logic                   step_pin_select,
  output logic                        clock_output_pin,
  output logic                        clock_output_enable,
  output logic                        first_output_divider_pd,
  output logic                        clock_input_enable,
  output logic [COCR_FINE_W-1:0]      fine_latency_value,
  output logic signed [7:0]           coarse_phase_applied
);

  initial begin
    if (DIV_HALF < 2) $error("DIV_HALF must be at least two");
    if (DIV_HALF > 255) $error("DIV_HALF must fit eight bits");
    if (SLEW_STEP_CYC < 1) $error("SLEW_STEP_CYC must be positive");
  end

  typedef struct packed {
    logic [7:0]             hold_ctrl;
    logic [7:0]             outdis_ctrl;
    logic [7:0]             inpd_ctrl;
    logic [7:0]             coarse;
    logic [7:0]             fine_hi;
    logic [7:0]             fine_lo;
    logic [COCR_FINE_W-1:0] fine_held;
    logic [COCR_FINE_W-1:0] fine_out;
    logic [7:0]             div_cnt;
    logic                   div_phase;
    logic                   clk_out;
    logic                   out_en;
    logic                   div_pd;
    logic                   in_en;
    logic signed [7:0]      phase_out;
    logic [7:0]             rdata;
  } cocr_state_t;

  cocr_state_t st_reg;
  cocr_state_t st_next;

  logic              step_sel_sync;
  logic signed [7:0] slew_applied;
  logic              slew_up;
  logic              slew_dn;
  logic              slew_settled;

  cocr_sync2 u_step_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (step_pin_select),
    .sync_out (step_sel_sync)
  );

  // Pin select freezes the slew where it stands
  cocr_phase_slew #(
    .STEP_CYC (SLEW_STEP_CYC)
  ) u_slew (
    .clk     (clk),
    .rstn    (rstn),
    .enable  (!step_sel_sync),
    .target  (signed'(st_reg.coarse)),
    .applied (slew_applied),
    .step_up (slew_up),
    .step_dn (slew_dn),
    .settled (slew_settled)
  );

  logic                   wr_hold;
  logic                   wr_outdis;
  logic                   wr_inpd;
  logic                   wr_coarse;
  logic                   wr_fine_hi;
  logic                   wr_fine_lo;
  logic [COCR_FINE_W-1:0] fine_live;
  logic                   commit_next;
  cocr_hold_t             hold_mode;
  logic [8:0]             div_sum;
  logic [8:0]             div_inc;
  logic                   boundary;
  logic                   disabled;
  logic [7:0]             rd_mux;

  always_comb begin
    wr_hold    = reg_wr && (reg_addr == COCR_OFS_HOLD);
    wr_outdis  = reg_wr && (reg_addr == COCR_OFS_OUTDIS);
    wr_inpd    = reg_wr && (reg_addr == COCR_OFS_INPD);
    wr_coarse  = reg_wr && (reg_addr == COCR_OFS_COARSE);
    wr_fine_hi = reg_wr && (reg_addr == COCR_OFS_FINE_HI);
    wr_fine_lo = reg_wr && (reg_addr == COCR_OFS_FINE_LO);
  end

  // Register writes; only documented fields are stored
  always_comb begin
    st_next = st_reg;
    if (wr_hold) begin
      st_next.hold_ctrl = '0;
      st_next.hold_ctrl[COCR_HOLD_MSB:COCR_HOLD_LSB] =
        reg_wdata[COCR_HOLD_MSB:COCR_HOLD_LSB];
    end
    if (wr_outdis) begin
      st_next.outdis_ctrl = '0;
      st_next.outdis_ctrl[COCR_OUTDIS_BIT] = reg_wdata[COCR_OUTDIS_BIT];
    end
    if (wr_inpd) begin
      st_next.inpd_ctrl = COCR_INPD_RSVD;
      st_next.inpd_ctrl[COCR_INPD_BIT] = reg_wdata[COCR_INPD_BIT];
    end
    if (wr_coarse) begin
      st_next.coarse = reg_wdata;
    end
    if (wr_fine_hi) begin
      st_next.fine_hi = reg_wdata;
    end
    if (wr_fine_lo) begin
      st_next.fine_lo = reg_wdata;
    end

    // Fine latency: live value from the registers
    fine_live = {st_next.fine_hi[COCR_FINE_HI_W-1:0], st_next.fine_lo};
    commit_next = st_next.fine_hi[COCR_COMMIT_BIT];
    // Copy tracks the old registers while committed, so clearing the
    // commit bit freezes the value in force just before that write
    if (st_reg.fine_hi[COCR_COMMIT_BIT]) begin
      st_next.fine_held = {st_reg.fine_hi[COCR_FINE_HI_W-1:0],
                           st_reg.fine_lo};
    end
    if (commit_next) begin
      st_next.fine_out = fine_live;
    end else begin
      st_next.fine_out = st_next.fine_held;
    end

    // Output path
    hold_mode = cocr_hold_t'(st_reg.hold_ctrl[COCR_HOLD_MSB:COCR_HOLD_LSB]);
    disabled  = st_reg.outdis_ctrl[COCR_OUTDIS_BIT];
    st_next.out_en = !disabled;
    st_next.div_pd = disabled;
    st_next.in_en  = !st_reg.inpd_ctrl[COCR_INPD_BIT];

    // A phase step stalls or skips one count of the divider
    if (slew_up) begin
      div_inc = 9'h0;
    end else if (slew_dn) begin
      div_inc = 9'h2;
    end else begin
      div_inc = 9'h1;
    end
    div_sum  = {1'b0, st_reg.div_cnt} + div_inc;
    boundary = (div_sum >= 9'(DIV_HALF));

    if (disabled) begin
      st_next.div_cnt   = '0;
      st_next.div_phase = 1'b0;
      st_next.clk_out   = 1'b0;
    end else begin
      if (boundary) begin
        st_next.div_cnt   = 8'(div_sum - 9'(DIV_HALF));
        st_next.div_phase = !st_reg.div_phase;
      end else begin
        st_next.div_cnt   = div_sum[7:0];
      end
      // Level changes only at half-period boundaries, but a down step skips
      // a divider count, so that half period can end a clock early
      if (boundary) begin
        unique case (hold_mode)
          COCR_HOLD_LOW:  st_next.clk_out = 1'b0;
          COCR_HOLD_HIGH: st_next.clk_out = 1'b1;
          COCR_HOLD_RSVD: st_next.clk_out = !st_reg.div_phase;
          default:        st_next.clk_out = !st_reg.div_phase;
        endcase
      end
    end

    st_next.phase_out = slew_applied;

    // Readback
    unique case (reg_addr)
      COCR_OFS_HOLD:    rd_mux = st_reg.hold_ctrl;
      COCR_OFS_OUTDIS:  rd_mux = st_reg.outdis_ctrl;
      COCR_OFS_INPD:    rd_mux = st_reg.inpd_ctrl;
      COCR_OFS_COARSE:  rd_mux = st_reg.coarse;
      COCR_OFS_FINE_HI: rd_mux = st_reg.fine_hi;
      COCR_OFS_FINE_LO: rd_mux = st_reg.fine_lo;
      COCR_OFS_PHASE:   rd_mux = slew_applied;
      COCR_OFS_STATUS: begin
        rd_mux = '0;
        rd_mux[COCR_ST_SETTLED] = slew_settled;
        rd_mux[COCR_ST_LEVEL]   = st_reg.clk_out;
        rd_mux[COCR_ST_STEPSEL] = step_sel_sync;
      end
      default:          rd_mux = '0;
    endcase
    st_next.rdata = reg_rd ? rd_mux : '0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg             <= '0;
      st_reg.hold_ctrl   <= COCR_RST_HOLD;
      st_reg.outdis_ctrl <= COCR_RST_OUTDIS;
      st_reg.inpd_ctrl   <= COCR_RST_INPD;
      st_reg.coarse      <= COCR_RST_COARSE;
      st_reg.fine_hi     <= COCR_RST_FINE_HI;
      st_reg.fine_lo     <= COCR_RST_FINE_LO;
      st_reg.out_en      <= 1'b1;
      st_reg.in_en       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata               = st_reg.rdata;
  assign clock_output_pin        = st_reg.clk_out;
  assign clock_output_enable     = st_reg.out_en;
  assign first_output_divider_pd = st_reg.div_pd;
  assign clock_input_enable      = st_reg.in_en;
  assign fine_latency_value      = st_reg.fine_out;
  assign coarse_phase_applied    = st_reg.phase_out;

endmodule

// >>> verif/cocr_top_sva.sv
`timescale 1ns/1ps
module cocr_top_chk
  import cocr_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              step_pin_select,
  input wire logic              clock_output_pin,
  input wire logic              clock_output_enable,
  input wire logic              first_output_divider_pd,
  input wire logic              clock_input_enable,
  input wire logic [14:0]       fine_latency_value,
  input wire logic signed [7:0] coarse_phase_applied
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadows follow host writes at register timing
  logic [1:0]  hold_s;
  logic        dis_s;
  logic        inpd_s;
  logic        commit_s;
  logic [14:0] fine_s;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_s   <= 2'h0;
      dis_s    <= 1'b0;
      inpd_s   <= 1'b0;
      commit_s <= 1'b1;
      fine_s   <= 15'h0000;
    end else if (reg_wr) begin
      if (reg_addr == COCR_OFS_HOLD) hold_s <= reg_wdata[5:4];
      if (reg_addr == COCR_OFS_OUTDIS) dis_s <= reg_wdata[2];
      if (reg_addr == COCR_OFS_INPD) inpd_s <= reg_wdata[0];
      if (reg_addr == COCR_OFS_FINE_HI) {commit_s, fine_s[14:8]} <= reg_wdata;
      if (reg_addr == COCR_OFS_FINE_LO) fine_s[7:0] <= reg_wdata;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_out_disable: assert property (clock_output_enable == !$past(dis_s))
    else $error("output enable does not follow disable bit");
  a_div_pd_pair: assert property (first_output_divider_pd == !clock_output_enable)
    else $error("divider powerdown differs from output disable");
  a_input_buf: assert property (clock_input_enable == !$past(inpd_s))
    else $error("input buffer enable does not follow powerdown bit");
  a_hold_low: assert property ((hold_s == 2'h1) [*8] |-> !clock_output_pin)
    else $error("output not held low");
  a_hold_high: assert property ((hold_s == 2'h2 && !dis_s) [*8] |-> clock_output_pin)
    else $error("output not held high");
  a_no_runt: assert property ($rose(clock_output_pin) && !dis_s |=> clock_output_pin || dis_s)
    else $error("one cycle pulse on output");
  // Effective value moves on the same edge as the register write
  a_fine_direct: assert property (commit_s |-> fine_latency_value == fine_s)
    else $error("fine latency not taken from registers");
  a_fine_held: assert property (!commit_s |-> $stable(fine_latency_value))
    else $error("fine latency moved while uncommitted");
  a_phase_gradual: assert property ($changed(coarse_phase_applied) |->
    coarse_phase_applied == $past(coarse_phase_applied) + 8'sd1 ||
    coarse_phase_applied == $past(coarse_phase_applied) - 8'sd1)
    else $error("coarse phase jumped by more than one step");
  c_hold_low: cover property (hold_s == 2'h1 && !clock_output_pin);
  c_commit: cover property (!commit_s ##1 commit_s);
  c_slew: cover property ($changed(coarse_phase_applied));
endmodule

bind cocr_top cocr_top_chk chk_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .step_pin_select(step_pin_select),
  .clock_output_pin(clock_output_pin),
  .clock_output_enable(clock_output_enable),
  .first_output_divider_pd(first_output_divider_pd),
  .clock_input_enable(clock_input_enable),
  .fine_latency_value(fine_latency_value),
  .coarse_phase_applied(coarse_phase_applied));

// >>> verif/tb_cocr_top.sv
`timescale 1ns/1ps
module tb_cocr_top
  import cocr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        step_pin_select = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        clock_output_pin;
  logic        clock_output_enable;
  logic        first_output_divider_pd;
  logic        clock_input_enable;
  logic [14:0] fine_latency_value;
  logic [7:0]  coarse_phase_applied;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  int          edges;
  localparam logic [7:0] OFS[6] = '{8'h08, 8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12};
  localparam logic [7:0] RST[6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h80, 8'h00};

  always #10 clk = ~clk;

  cocr_top #(.DIV_HALF(4), .SLEW_STEP_CYC(4)) dut_u (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .step_pin_select(step_pin_select),
    .clock_output_pin(clock_output_pin),
    .clock_output_enable(clock_output_enable),
    .first_output_divider_pd(first_output_divider_pd),
    .clock_input_enable(clock_input_enable),
    .fine_latency_value(fine_latency_value),
    .coarse_phase_applied(coarse_phase_applied));

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Output level changes seen over sixteen clocks
  task automatic count_edges(output int n);
    logic p;
    n = 0;
    repeat (16) begin
      p = clock_output_pin;
      settle(1);
      if (clock_output_pin !== p) n++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(OFS[i], RST[i]);
    wr(8'h20, 8'haa);
    rd(8'h20, 8'h00);
    wr(8'h08, 8'h10);
    settle(12);
    repeat (8) begin
      chk(clock_output_pin, 1'b0);
      settle(1);
    end
    wr(8'h08, 8'h20);
    settle(12);
    repeat (8) begin
      chk(clock_output_pin, 1'b1);
      settle(1);
    end
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h30);
    settle(4);
    count_edges(edges);
    chk(16'(edges), 16'h0004);
    wr(8'h08, 8'h00);
    settle(6);
    count_edges(edges);
    chk(16'(edges), 16'h0004);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h04);
    chk(clock_output_enable, 1'b0);
    chk(first_output_divider_pd, 1'b1);
    chk(clock_output_pin, 1'b0);
    wr(8'h0a, 8'h00);
    settle(2);
    chk(clock_output_enable, 1'b1);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h41);
    chk(clock_input_enable, 1'b0);
    wr(8'h0b, 8'h00);
    settle(2);
    chk(clock_input_enable, 1'b1);
    wr(8'h11, 8'h81);
    wr(8'h12, 8'h23);
    settle(2);
    chk(fine_latency_value, 16'h0123);
    wr(8'h11, 8'h05);
    settle(2);
    chk(fine_latency_value, 16'h0123);
    wr(8'h12, 8'h66);
    rd(8'h11, 8'h05);
    chk(fine_latency_value, 16'h0123);
    wr(8'h11, 8'h85);
    settle(2);
    chk(fine_latency_value, 16'h0566);
    wr(8'h10, 8'hfe);
    settle(40);
    chk(coarse_phase_applied, 8'hfe);
    wr(8'h10, 8'h7f);
    settle(700);
    chk(coarse_phase_applied, 8'h7f);
    @(posedge clk);
    step_pin_select <= 1'b1;
    wr(8'h10, 8'h80);
    settle(40);
    chk(coarse_phase_applied, 8'h7f);
    @(posedge clk);
    step_pin_select <= 1'b0;
    settle(20);
    chk(coarse_phase_applied[7], 1'b0);
    settle(1100);
    chk(coarse_phase_applied, 8'h80);
    rd(8'h13, 8'h80);
    tally_and_finish();
  end
endmodule
